/* File: sps_pkg.sv */
package sps_pkg;

	// ============================================================
	// Register map (byte addresses; 0x0F57 is not word aligned, so indices)
	localparam logic [11:0] SWAP_CTRL_IDX   = 12'hF57;
	localparam logic [11:0] ROUTE_SEL_IDX   = 12'hFCB;
	localparam logic [11:0] IRQ_STATUS_IDX  = 12'hFD0;
	localparam logic [11:0] IRQ_MASK_IDX    = 12'hFD1;
	localparam int          ADDR_W          = 14;

	// ============================================================
	// Reset values and write masks
	localparam logic [7:0]  SWAP_CTRL_RST   = 8'h00;
	localparam logic [7:0]  ROUTE_SEL_RST   = 8'h00;
	localparam logic [7:0]  SWAP_CTRL_WMASK = 8'h03;
	localparam logic [7:0]  ROUTE_SEL_WMASK = 8'hD3;

	// ============================================================
	// Field positions
	localparam int TMR_SEL_LSB  = 6;
	localparam int GRP_SEL_BIT  = 4;
	localparam int PAIR_LSB     = 0;
	localparam int SWAP0_BIT    = 0;
	localparam int SWAP1_BIT    = 1;

	// ============================================================
	// Interrupt status bits (slot activity)
	localparam int IRQ_BITS     = 3;
	localparam int IRQ_TX_SLOT  = 0;
	localparam int IRQ_RX_SLOT  = 1;
	localparam int IRQ_SH_SLOT  = 2;

	// ============================================================
	// Encodings
	typedef enum logic [1:0] {
		SPS_PAIR_ASYNC_TWI  = 2'h0,
		SPS_PAIR_ASYNC_SYNC = 2'h1,
		SPS_PAIR_SYNC_TWI   = 2'h2,
		SPS_PAIR_RESV       = 2'h3
	} sps_pair_e;

	typedef enum logic [1:0] {
		SPS_TMR_DEDICATED = 2'h0,
		SPS_TMR_ASYNC0_RX = 2'h1,
		SPS_TMR_ASYNC1_RX = 2'h2,
		SPS_TMR_RESV      = 2'h3
	} sps_tmr_e;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

/* File: sps_cfg_if.sv */
`timescale 1ns/1ps
interface sps_cfg_if;
	logic [7:0] route_sel;
	logic [7:0] swap_ctrl;

	modport ctrl (output route_sel, output swap_ctrl);
	modport mux  (input route_sel, input swap_ctrl);
endinterface

/* File: sps_mux.sv */
`timescale 1ns/1ps
module sps_mux (
	sps_cfg_if.mux      cfg,
	input  wire logic   async0_tx,
	input  wire logic   async1_tx,
	input  wire logic   sync_data_out,
	input  wire logic   sync_clk_out,
	input  wire logic   twi_sda_out,
	input  wire logic   twi_scl_out,
	input  wire logic   async0_tx_irq,
	input  wire logic   async0_rx_irq,
	input  wire logic   sync_serial_irq,
	input  wire logic   two_wire_irq,
	input  wire logic   p72_in,
	input  wire logic [2:0] p2lo_in,
	input  wire logic [2:0] pb_in,
	input  wire logic [1:0] p2hi_in,
	input  wire logic [1:0] p9_in,
	output logic [2:0]  p2lo_out,
	output logic [2:0]  p2lo_sel,
	output logic [2:0]  pb_out,
	output logic [2:0]  pb_sel,
	output logic [2:0]  p2hi_out,
	output logic [2:0]  p2hi_sel,
	output logic [1:0]  p9_out,
	output logic [1:0]  p9_sel,
	output logic        async0_rx,
	output logic        async1_rx,
	output logic        sync_data_in,
	output logic        twi_sda_in,
	output logic        twi_scl_in,
	output logic        timer_a0_input,
	output logic [2:0]  irq_slot
);
	// ============================================================
	// Decode
	sps_pkg::sps_pair_e pair;
	logic grp, sw0, sw1, a0_on, s0_on, t0_on;
	logic [2:0] grp_in, grp_out, grp_sel;

	assign pair  = sps_pkg::sps_pair_e'(cfg.route_sel[sps_pkg::PAIR_LSB +: 2]);
	assign grp   = cfg.route_sel[sps_pkg::GRP_SEL_BIT];
	assign sw0   = cfg.swap_ctrl[sps_pkg::SWAP0_BIT];
	assign sw1   = cfg.swap_ctrl[sps_pkg::SWAP1_BIT];
	// Reserved pairing code enables nothing
	assign a0_on = (pair == sps_pkg::SPS_PAIR_ASYNC_TWI) ||
	               (pair == sps_pkg::SPS_PAIR_ASYNC_SYNC);
	assign s0_on = (pair == sps_pkg::SPS_PAIR_ASYNC_SYNC) ||
	               (pair == sps_pkg::SPS_PAIR_SYNC_TWI);
	assign t0_on = (pair == sps_pkg::SPS_PAIR_ASYNC_TWI) ||
	               (pair == sps_pkg::SPS_PAIR_SYNC_TWI);
	assign grp_in = grp ? pb_in : p2lo_in;

	// ============================================================
	// Group pins: async 0 or sync serial 0
	always_comb begin
		grp_out   = 3'h0;
		grp_sel   = 3'h0;
		async0_rx = 1'b1;
		sync_data_in = 1'b0;
		if (a0_on) begin
			grp_sel = 3'h3;
			grp_out = sw0 ? {2'h0, 1'b0} | 3'(async0_tx) << 1 : {2'h0, async0_tx};
			async0_rx = sw0 ? grp_in[0] : grp_in[1];
		end
		if (pair == sps_pkg::SPS_PAIR_SYNC_TWI) begin
			grp_sel = 3'h7;
			grp_out = {sync_clk_out, 1'b0, sync_data_out};
			sync_data_in = grp_in[1];
		end
		if (pair == sps_pkg::SPS_PAIR_ASYNC_SYNC) begin
			sync_data_in = p2hi_in[1];
		end
	end

	// Place group onto port 2 low pins or port B pins
	assign p2lo_out = grp ? 3'h0 : grp_out;
	assign p2lo_sel = grp ? 3'h0 : grp_sel;
	assign pb_out   = grp ? grp_out : 3'h0;
	assign pb_sel   = grp ? grp_sel : 3'h0;

	// ============================================================
	// Port 2 upper pins: two-wire or sync serial 0
	always_comb begin
		p2hi_out   = 3'h0;
		p2hi_sel   = 3'h0;
		twi_sda_in = 1'b1;
		twi_scl_in = 1'b1;
		if (t0_on) begin
			p2hi_sel   = 3'h3;
			p2hi_out   = {1'b0, twi_scl_out, twi_sda_out};
			twi_sda_in = p2hi_in[0];
			twi_scl_in = p2hi_in[1];
		end else if (s0_on) begin
			p2hi_sel = 3'h7;
			p2hi_out = {sync_clk_out, 1'b0, sync_data_out};
		end
	end

	// ============================================================
	// Async 1 on port 9, always routed
	assign p9_sel    = 2'h3;
	assign p9_out    = sw1 ? {async1_tx, 1'b0} : {1'b0, async1_tx};
	assign async1_rx = sw1 ? p9_in[0] : p9_in[1];

	// ============================================================
	// Timer capture input select; reserved reads dedicated pin
	always_comb begin
		case (sps_pkg::sps_tmr_e'(cfg.route_sel[sps_pkg::TMR_SEL_LSB +: 2]))
			sps_pkg::SPS_TMR_ASYNC0_RX: timer_a0_input = p2lo_in[1];
			sps_pkg::SPS_TMR_ASYNC1_RX: timer_a0_input = p9_in[1];
			default:                    timer_a0_input = p72_in;
		endcase
	end

	// ============================================================
	// Interrupt slot steering
	always_comb begin
		irq_slot = 3'h0;
		case (pair)
			sps_pkg::SPS_PAIR_ASYNC_TWI:
				irq_slot = {two_wire_irq, async0_rx_irq, async0_tx_irq};
			sps_pkg::SPS_PAIR_ASYNC_SYNC:
				irq_slot = {sync_serial_irq, async0_rx_irq, async0_tx_irq};
			sps_pkg::SPS_PAIR_SYNC_TWI:
				irq_slot = {two_wire_irq, sync_serial_irq, 1'b0};
			default:
				irq_slot = 3'h0;
		endcase
	end
endmodule // sps_mux

/* File: sps_top.sv */
// Overview of operation
// - Timer bits 7:6 choose capture pin
// - Group bit 4 picks port 2 or B
// - Pairing bits 1:0 enable two controllers; reserved code 3 enables none
// - Async 0 swap exchanges transmit/receive pins
// - Async 1 swap exchanges port 9 pins
// - Two-wire on port 2 bits 3,4
// - Interrupt slots follow pairing code
// - Port B also needs function control
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module sps_top (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [13:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [13:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        async0_tx,
	input  wire logic        async1_tx,
	input  wire logic        sync_data_out,
	input  wire logic        sync_clk_out,
	input  wire logic        twi_sda_out,
	input  wire logic        twi_scl_out,
	input  wire logic        async0_tx_irq,
	input  wire logic        async0_rx_irq,
	input  wire logic        sync_serial_irq,
	input  wire logic        two_wire_irq,
	input  wire logic        p72_in,
	input  wire logic [2:0]  p2lo_in,
	input  wire logic [2:0]  pb_in,
	input  wire logic [1:0]  p2hi_in,
	input  wire logic [1:0]  p9_in,
	output logic [2:0]       p2lo_out,
	output logic [2:0]       p2lo_sel,
	output logic [2:0]       pb_out,
	output logic [2:0]       pb_sel,
	output logic [2:0]       p2hi_out,
	output logic [2:0]       p2hi_sel,
	output logic [1:0]       p9_out,
	output logic [1:0]       p9_sel,
	output logic             async0_rx,
	output logic             async1_rx,
	output logic             sync_data_in,
	output logic             twi_sda_in,
	output logic             twi_scl_in,
	output logic             timer_a0_input,
	output logic [2:0]       irq_slot,
	output logic             irq
);
	// ============================================================
	// State
	typedef struct packed {
		logic [7:0]  route_sel;
		logic [7:0]  swap_ctrl;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic [2:0]  slot_prev;
		logic        aw_held;
		logic [13:0] aw_addr;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [2:0]  p2lo_out, p2lo_sel, pb_out, pb_sel, p2hi_out, p2hi_sel;
		logic [1:0]  p9_out, p9_sel;
		logic [4:0]  rx_lines;
		logic        tmr;
		logic [2:0]  slot;
		logic        irq;
	} sps_state_s;

	sps_state_s q, d;

	// Mux outputs before registering
	logic [2:0] m_p2lo_out, m_p2lo_sel, m_pb_out, m_pb_sel, m_p2hi_out, m_p2hi_sel;
	logic [1:0] m_p9_out, m_p9_sel;
	logic       m_a0rx, m_a1rx, m_sdi, m_sda, m_scl, m_tmr;
	logic [2:0] m_slot;

	sps_cfg_if cfg ();
	assign cfg.route_sel = q.route_sel;
	assign cfg.swap_ctrl = q.swap_ctrl;

	// ============================================================
	// Routing logic
	sps_mux u_mux (
		.cfg             (cfg.mux),
		.async0_tx       (async0_tx),
		.async1_tx       (async1_tx),
		.sync_data_out   (sync_data_out),
		.sync_clk_out    (sync_clk_out),
		.twi_sda_out     (twi_sda_out),
		.twi_scl_out     (twi_scl_out),
		.async0_tx_irq   (async0_tx_irq),
		.async0_rx_irq   (async0_rx_irq),
		.sync_serial_irq (sync_serial_irq),
		.two_wire_irq    (two_wire_irq),
		.p72_in          (p72_in),
		.p2lo_in         (p2lo_in),
		.pb_in           (pb_in),
		.p2hi_in         (p2hi_in),
		.p9_in           (p9_in),
		.p2lo_out        (m_p2lo_out),
		.p2lo_sel        (m_p2lo_sel),
		.pb_out          (m_pb_out),
		.pb_sel          (m_pb_sel),
		.p2hi_out        (m_p2hi_out),
		.p2hi_sel        (m_p2hi_sel),
		.p9_out          (m_p9_out),
		.p9_sel          (m_p9_sel),
		.async0_rx       (m_a0rx),
		.async1_rx       (m_a1rx),
		.sync_data_in    (m_sdi),
		.twi_sda_in      (m_sda),
		.twi_scl_in      (m_scl),
		.timer_a0_input  (m_tmr),
		.irq_slot        (m_slot)
	);

	// Byte address of a register index
	function automatic logic [13:0] reg_addr(input logic [11:0] idx);
		reg_addr = {idx, 2'b00};
	endfunction

	// Read data for an address; unmapped flagged separately
	function automatic logic [31:0] rd_word(input sps_state_s s, input logic [13:0] a);
		rd_word = 32'h0000_0000;
		if (a == reg_addr(sps_pkg::SWAP_CTRL_IDX))
			rd_word = {24'h000000, s.swap_ctrl};
		else if (a == reg_addr(sps_pkg::ROUTE_SEL_IDX))
			rd_word = {24'h000000, s.route_sel};
		else if (a == reg_addr(sps_pkg::IRQ_STATUS_IDX))
			rd_word = {29'h0, s.irq_stat};
		else if (a == reg_addr(sps_pkg::IRQ_MASK_IDX))
			rd_word = {29'h0, s.irq_mask};
	endfunction

	function automatic logic mapped(input logic [13:0] a);
		mapped = (a == reg_addr(sps_pkg::SWAP_CTRL_IDX)) ||
		         (a == reg_addr(sps_pkg::ROUTE_SEL_IDX)) ||
		         (a == reg_addr(sps_pkg::IRQ_STATUS_IDX)) ||
		         (a == reg_addr(sps_pkg::IRQ_MASK_IDX));
	endfunction

	// ============================================================
	// Next state
	always_comb begin
		logic [2:0] rise;
		logic [2:0] w1c;
		logic       do_wr;
		d    = q;
		rise = m_slot & ~q.slot_prev;
		w1c  = 3'h0;
		// Both halves held and no response pending
		do_wr = q.aw_held && q.w_held && !q.bvalid;
		// Write channel capture, either order
		if (s_axi_awvalid && !q.aw_held && !q.bvalid) begin
			d.aw_held = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !q.w_held && !q.bvalid) begin
			d.w_held = 1'b1;
			d.w_data = s_axi_wdata;
			d.w_strb = s_axi_wstrb;
		end
		if (do_wr) begin
			d.aw_held = 1'b0;
			d.w_held  = 1'b0;
			d.bvalid  = 1'b1;
			d.bresp   = mapped(q.aw_addr) ? sps_pkg::AXI_OKAY : sps_pkg::AXI_SLVERR;
			if (q.w_strb[0]) begin
				// Selection change takes effect next cycle; software keeps peers stopped
				if (q.aw_addr == reg_addr(sps_pkg::ROUTE_SEL_IDX))
					d.route_sel = q.w_data[7:0] & sps_pkg::ROUTE_SEL_WMASK;
				if (q.aw_addr == reg_addr(sps_pkg::SWAP_CTRL_IDX))
					d.swap_ctrl = q.w_data[7:0] & sps_pkg::SWAP_CTRL_WMASK;
				if (q.aw_addr == reg_addr(sps_pkg::IRQ_MASK_IDX))
					d.irq_mask = q.w_data[2:0];
				if (q.aw_addr == reg_addr(sps_pkg::IRQ_STATUS_IDX))
					w1c = q.w_data[2:0];
			end
		end
		if (q.bvalid && s_axi_bready)
			d.bvalid = 1'b0;
		// Read channel
		if (s_axi_arvalid && !q.rvalid) begin
			d.rvalid = 1'b1;
			d.rdata  = rd_word(q, s_axi_araddr);
			d.rresp  = mapped(s_axi_araddr) ? sps_pkg::AXI_OKAY : sps_pkg::AXI_SLVERR;
		end else if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		// Sticky slot events, set wins over clear
		d.slot_prev = m_slot;
		d.irq_stat  = (q.irq_stat & ~w1c) | rise;
		d.irq       = |(d.irq_stat & d.irq_mask);
		// Registered routing outputs
		d.p2lo_out = m_p2lo_out;
		d.p2lo_sel = m_p2lo_sel;
		d.pb_out   = m_pb_out;
		d.pb_sel   = m_pb_sel;
		d.p2hi_out = m_p2hi_out;
		d.p2hi_sel = m_p2hi_sel;
		d.p9_out   = m_p9_out;
		d.p9_sel   = m_p9_sel;
		d.rx_lines = {m_a0rx, m_a1rx, m_sdi, m_sda, m_scl};
		d.tmr      = m_tmr;
		d.slot     = m_slot;
	end

	// ============================================================
	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q           <= '0;
			q.route_sel <= sps_pkg::ROUTE_SEL_RST;
			q.swap_ctrl <= sps_pkg::SWAP_CTRL_RST;
			q.rx_lines  <= 5'h1F;
		end else if (clk_en) begin
			q <= d;
		end
	end

	// ============================================================
	// Outputs
	assign s_axi_awready  = !q.aw_held && !q.bvalid;
	assign s_axi_wready   = !q.w_held && !q.bvalid;
	assign s_axi_bvalid   = q.bvalid;
	assign s_axi_bresp    = q.bresp;
	assign s_axi_arready  = !q.rvalid;
	assign s_axi_rvalid   = q.rvalid;
	assign s_axi_rdata    = q.rdata;
	assign s_axi_rresp    = q.rresp;
	assign p2lo_out       = q.p2lo_out;
	assign p2lo_sel       = q.p2lo_sel;
	assign pb_out         = q.pb_out;
	assign pb_sel         = q.pb_sel;
	assign p2hi_out       = q.p2hi_out;
	assign p2hi_sel       = q.p2hi_sel;
	assign p9_out         = q.p9_out;
	assign p9_sel         = q.p9_sel;
	assign {async0_rx, async1_rx, sync_data_in, twi_sda_in, twi_scl_in} = q.rx_lines;
	assign timer_a0_input = q.tmr;
	assign irq_slot       = q.slot;
	assign irq            = q.irq;
endmodule // sps_top

/* File: sps_props.sv */
`timescale 1ns/1ps
module sps_props (
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic [13:0] s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        async0_tx_irq,
	input wire logic        async0_rx_irq,
	input wire logic        sync_serial_irq,
	input wire logic        two_wire_irq,
	input wire logic        p72_in,
	input wire logic [2:0]  p2lo_in,
	input wire logic [2:0]  pb_in,
	input wire logic [1:0]  p2hi_in,
	input wire logic [1:0]  p9_in,
	input wire logic [2:0]  p2lo_sel,
	input wire logic [2:0]  pb_sel,
	input wire logic [2:0]  p2hi_sel,
	input wire logic        async0_rx,
	input wire logic        async1_rx,
	input wire logic        sync_data_in,
	input wire logic        twi_sda_in,
	input wire logic        twi_scl_in,
	input wire logic        timer_a0_input,
	input wire logic [2:0]  irq_slot
);
	// ============================================================
	// Shadow of the routing registers, one cycle behind the design
	localparam logic [13:0] A_RS = {sps_pkg::ROUTE_SEL_IDX, 2'h0};
	localparam logic [13:0] A_SW = {sps_pkg::SWAP_CTRL_IDX, 2'h0};
	logic [13:0] wa_q;
	logic [8:0]  wd_q;
	logic [7:0]  rs_q;
	logic [1:0]  sw_q, pr, p9_q, hi_q;
	logic [2:0]  lo_q, pb_q, gi;
	logic        bv_q, g;
	assign pr = rs_q[1:0];
	assign g  = rs_q[4];
	assign gi = g ? pb_q : lo_q;
	// Captures a write and commits it when its OKAY response appears
	always_ff @(posedge aclk) begin
		bv_q <= s_axi_bvalid;
		{lo_q, pb_q, hi_q, p9_q} <= {p2lo_in, pb_in, p2hi_in, p9_in};
		if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) wd_q <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
		if (!aresetn) begin
			rs_q <= 8'h00;
			sw_q <= 2'h0;
		end else if (s_axi_bvalid && !bv_q && s_axi_bresp == sps_pkg::AXI_OKAY && wd_q[8]) begin
			if (wa_q == A_RS) rs_q <= wd_q[7:0] & sps_pkg::ROUTE_SEL_WMASK;
			if (wa_q == A_SW) sw_q <= wd_q[1:0];
		end
	end

	// ============================================================
	// Routing properties
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	a_timer_route: assert property ($past(aresetn) |-> timer_a0_input ==
		(rs_q[7:6] == 2'h1 ? lo_q[1] : rs_q[7:6] == 2'h2 ? p9_q[1] : $past(p72_in)))
		else $error("timer capture pin wrong");
	a_async0_rx: assert property ($past(aresetn) |-> async0_rx == (pr[1] ? 1'h1 : gi[!sw_q[0]]))
		else $error("async 0 receive pin wrong");
	a_async1_rx: assert property ($past(aresetn) |-> async1_rx == p9_q[!sw_q[1]])
		else $error("async 1 receive pin wrong");
	a_twi_route: assert property ($past(aresetn) && !pr[0] |-> {twi_scl_in, twi_sda_in} == hi_q)
		else $error("two-wire lines wrong");
	a_sync_in: assert property ($past(aresetn) |-> sync_data_in ==
		(pr == 2'h1 ? hi_q[1] : pr == 2'h2 ? gi[1] : 1'h0))
		else $error("sync data in wrong");
	a_slot_map: assert property ($past(aresetn) |-> irq_slot == (pr == 2'h3 ? 3'h0 :
		pr == 2'h2 ? {$past(two_wire_irq), $past(sync_serial_irq), 1'h0} :
		{pr[0] ? $past(sync_serial_irq) : $past(two_wire_irq), $past(async0_rx_irq),
		$past(async0_tx_irq)}))
		else $error("interrupt slots wrong");
	a_unused_pins: assert property ($past(aresetn) && pr == 2'h3 |->
		{p2lo_sel, pb_sel, p2hi_sel} == 9'h000)
		else $error("reserved pairing owns pins");
	a_group_pick: assert property ($past(aresetn) && pr != 2'h3 |->
		(g ? p2lo_sel : pb_sel) == 3'h0 && (g ? pb_sel : p2lo_sel) != 3'h0)
		else $error("wrong pin group owned");
	c_sync_group: cover property (pr == 2'h2 && g);
	c_swap_both: cover property (sw_q == 2'h3 && pr == 2'h0);
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == sps_pkg::AXI_SLVERR);
endmodule // sps_props

bind sps_top sps_props sps_props_inst (.*);

/* File: sps_peer.sv */
`timescale 1ns/1ps
module sps_peer (
	input  wire logic [16:0] stim,
	output logic             async0_tx,
	output logic             async1_tx,
	output logic             sync_data_out,
	output logic             sync_clk_out,
	output logic             twi_sda_out,
	output logic             twi_scl_out,
	output logic             p72_in,
	output logic [2:0]       p2lo_in,
	output logic [2:0]       pb_in,
	output logic [1:0]       p2hi_in,
	output logic [1:0]       p9_in
);
	// ============================================================
	// Controller outputs and pin levels, frozen while registers change
	assign {p9_in, p2hi_in, pb_in, p2lo_in, p72_in, twi_scl_out, twi_sda_out, sync_clk_out,
		sync_data_out, async1_tx, async0_tx} = stim;
endmodule // sps_peer

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	// ============================================================
	// Signals
	localparam logic [13:0] A_SW = {sps_pkg::SWAP_CTRL_IDX, 2'h0};
	localparam logic [13:0] A_RS = {sps_pkg::ROUTE_SEL_IDX, 2'h0};
	localparam logic [13:0] A_ST = {sps_pkg::IRQ_STATUS_IDX, 2'h0};
	localparam logic [13:0] A_MK = {sps_pkg::IRQ_MASK_IDX, 2'h0};
	logic        aclk = 1'h0, aresetn = 1'h0, clk_en = 1'h1;
	logic [13:0] s_axi_awaddr = 14'h0, s_axi_araddr = 14'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, p2hi_in, p9_in, p9_out, p9_sel;
	logic        async0_tx, async1_tx, sync_data_out, sync_clk_out, twi_sda_out, twi_scl_out;
	logic        async0_tx_irq = 1'h0, async0_rx_irq = 1'h0;
	logic        sync_serial_irq = 1'h0, two_wire_irq = 1'h0;
	logic        p72_in, async0_rx, async1_rx, sync_data_in, twi_sda_in, twi_scl_in;
	logic        timer_a0_input, irq;
	logic [2:0]  p2lo_in, pb_in, p2lo_out, p2lo_sel, pb_out, pb_sel, p2hi_out, p2hi_sel;
	logic [2:0]  irq_slot;
	logic [16:0] stim = 17'h0;
	integer      seed = 32'h926FAD54;
	int          n_mismatch = 0, total_checks = 0;

	// Clock of 40 ns period
	always #20 aclk = ~aclk;
	sps_top sps_top_inst (.*);
	sps_peer sps_peer_inst (.*);

	// ============================================================
	// Bus tasks and comparison
	task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'h0;
		r = s_axi_bresp;
	endtask

	task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'h0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Drives random pins and events, then compares against the routing model
	task automatic sample(input logic [7:0] rs, input logic [1:0] sw);
		int p, g, t;
		logic [2:0] gi, go, sl, es;
		p = rs[1:0];
		g = rs[4];
		t = rs[7:6];
		@(posedge aclk);
		stim <= 17'($random(seed));
		{two_wire_irq, sync_serial_irq, async0_rx_irq, async0_tx_irq} <= 4'($random(seed));
		repeat (2) @(posedge aclk);
		@(negedge aclk);
		gi = g ? pb_in : p2lo_in;
		go = g ? pb_out : p2lo_out;
		es = p == 3 ? 3'h0 : p == 2 ? 3'h7 : 3'h3;
		case (p)
			0: sl = {two_wire_irq, async0_rx_irq, async0_tx_irq};
			1: sl = {sync_serial_irq, async0_rx_irq, async0_tx_irq};
			2: sl = {two_wire_irq, sync_serial_irq, 1'h0};
			default: sl = 3'h0;
		endcase
		chk(timer_a0_input, t == 1 ? p2lo_in[1] : t == 2 ? p9_in[1] : p72_in);
		chk(async0_rx, p < 2 ? gi[!sw[0]] : 1'h1);
		chk({async1_rx, p9_out[sw[1]]}, {p9_in[!sw[1]], async1_tx});
		chk(p9_sel, 2'h3);
		chk({twi_scl_in, twi_sda_in}, p % 2 == 1 ? 2'h3 : p2hi_in);
		chk(sync_data_in, p == 1 ? p2hi_in[1] : p == 2 ? gi[1] : 1'h0);
		chk(irq_slot, sl);
		chk({p2lo_sel, pb_sel}, g ? {3'h0, es} : {es, 3'h0});
		chk(p2hi_sel, p == 3 ? 3'h0 : p == 1 ? 3'h7 : 3'h3);
		if (p < 2) chk(go[sw[0]], async0_tx);
		if (p == 2) chk({go[2], go[0]}, {sync_clk_out, sync_data_out});
		if (p == 1) chk({p2hi_out[2], p2hi_out[0]}, {sync_clk_out, sync_data_out});
		if (p % 2 == 0) chk(p2hi_out, {1'h0, twi_scl_out, twi_sda_out});
	endtask

	// ============================================================
	// Main sequence
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  rs;
		repeat (3) @(posedge aclk);
		aresetn <= 1'h1;
		rd(A_RS, d, r);
		chk(d, 32'h0);
		rd(A_SW, d, r);
		chk(d, 32'h0);
		wr(A_RS, 32'hFF, 4'h0, r);
		rd(A_RS, d, r);
		chk(d, 32'h0);
		wr(A_RS, 32'hFFFFFFFF, 4'hF, r);
		rd(A_RS, d, r);
		chk(d, 32'hD3);
		wr(A_SW, 32'hFFFFFFFF, 4'hF, r);
		rd(A_SW, d, r);
		chk(d, 32'h3);
		wr(14'h0, 32'h1, 4'hF, r);
		chk(r, sps_pkg::AXI_SLVERR);
		rd(14'h4, d, r);
		chk(d, 32'h0);
		chk(r, sps_pkg::AXI_SLVERR);
		$display("register test done");
		// Every pairing, group, swap and timer code; pins held during writes
		for (int k = 0; k < 128; k++) begin
			rs = {k[6:5], 1'h0, k[4], 2'h0, k[1:0]};
			wr(A_RS, {24'h0, rs | 8'h2C}, 4'h1, r);
			wr(A_SW, {30'h0, k[3:2]}, 4'h1, r);
			wr(A_ST, 32'h7, 4'h1, r);
			rd(A_RS, d, r);
			chk(d, {24'h0, rs});
			repeat (3) sample(rs, k[3:2]);
		end
		$display("routing test done");
		@(posedge aclk);
		{two_wire_irq, sync_serial_irq, async0_rx_irq, async0_tx_irq} <= 4'h0;
		wr(A_RS, 32'h0, 4'h1, r);
		wr(A_MK, 32'h0, 4'h1, r);
		wr(A_ST, 32'h7, 4'h1, r);
		rd(A_ST, d, r);
		chk(d, 32'h0);
		@(posedge aclk);
		async0_tx_irq <= 1'h1;
		@(posedge aclk);
		async0_tx_irq <= 1'h0;
		repeat (4) @(posedge aclk);
		chk(irq, 1'h0);
		rd(A_ST, d, r);
		chk(d, 32'h1);
		wr(A_MK, 32'h1, 4'h1, r);
		repeat (3) @(posedge aclk);
		chk(irq, 1'h1);
		wr(A_ST, 32'h1, 4'h1, r);
		repeat (3) @(posedge aclk);
		chk(irq, 1'h0);
		$display("interrupt test done");
		test_done();
	end

	// Cuts a hung run short
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		$display("[FAIL] %0t run timed out", $time);
		test_done();
	end
endmodule // tb_top
